/* File: pkg/sfs_defines.svh */
// Constants for the system fault status register bank
`ifndef SFS_DEFINES_SVH
`define SFS_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define SFS_IDX_SYS_FAULT 16'h0536
`define SFS_IDX_PARITY_FAULT 16'h053A
`define SFS_IDX_CONTROL 16'h0600

// ----------------------------------------
// System fault register fields
// ----------------------------------------
`define SFS_SYS_OSC_BIT 7
`define SFS_SYS_RSVD_BIT 6
`define SFS_SYS_EXT_FAULT_BIT 5
`define SFS_SYS_DIGITAL_RESET_FLAG_BIT 4
`define SFS_SYS_CTL_BIT 3
`define SFS_SYS_CTS_BIT 2
`define SFS_SYS_THERMAL_SHUTDOWN_FLAG_BIT 1
`define SFS_SYS_DIE_TEMP_WARNING_FLAG_BIT 0

// ----------------------------------------
// Parity fault register fields
// ----------------------------------------
`define SFS_PAR_TEMP_BIT 1
`define SFS_PAR_VOLT_BIT 0

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SFS_CTL_THR_LSB 0
`define SFS_CTL_THR_MSB 1
`define SFS_CTL_FAULT_IN_EN_BIT 2
`define SFS_CTL_LONG_SHDN_EN_BIT 3
`define SFS_CTL_CLEAR_BIT 7
`define SFS_CTL_WRITE_MASK 8'h0F
`define SFS_RESET_VALUE 8'h00

// ----------------------------------------
// Die temperature warning levels per threshold code
// ----------------------------------------
`define SFS_WARN_LVL0 8'h60
`define SFS_WARN_LVL1 8'h70
`define SFS_WARN_LVL2 8'h80
`define SFS_WARN_LVL3 8'h90

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define SFS_RESP_OKAY 2'h0
`define SFS_RESP_SLVERR 2'h2

`endif

/* File: pkg/sfs_pkg.sv */
// Types for the system fault status register bank
package sfs_pkg;

  // Over/under-temperature related configuration with stored parity bits
  typedef struct packed {
    logic [7:0] ot_threshold;
    logic [7:0] ut_threshold;
    logic [1:0] temp_compare_mode;
    logic [7:0] pin_config_1;
    logic [7:0] pin_config_2;
    logic [7:0] pin_config_3;
    logic [7:0] pin_config_4;
    logic [6:0] parity;
  } sfs_temp_cfg_s;

  // Over/under-voltage related configuration with stored parity bits
  typedef struct packed {
    logic [7:0] ov_threshold;
    logic [7:0] uv_threshold;
    logic [1:0] volt_compare_mode;
    logic [3:0] active_cell_count;
    logic [3:0] parity;
  } sfs_volt_cfg_s;

  // Fault event sources from neighbouring logic
  typedef struct packed {
    logic osc_out_of_range;
    logic ext_fault_pin;
    logic digital_reset;
    logic comm_timeout_long;
    logic comm_timeout_short;
    logic thermal_shutdown;
    logic [7:0] die_temp2;
  } sfs_events_s;

endpackage

/* File: core/sfs_parity_check.sv */
// Even parity checker over a set of packed configuration fields
`timescale 1ns/1ps
`default_nettype none

module sfs_parity_check #(
  parameter int NUM_FIELDS = 4,
  parameter int FIELD_WIDTH = 8
) (
  input wire logic [NUM_FIELDS*FIELD_WIDTH-1:0] i_fields,
  input wire logic [NUM_FIELDS-1:0] i_parity,
  input wire logic [NUM_FIELDS-1:0] i_field_used,
  output logic o_error
);

  logic [NUM_FIELDS-1:0] field_bad;

  // Unused bits of narrow fields are tied low by the caller
  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g = g + 1) begin : gen_field
      assign field_bad[g] = i_field_used[g] &
        ((^i_fields[g*FIELD_WIDTH +: FIELD_WIDTH]) ^ i_parity[g]);
    end
  endgenerate

  assign o_error = |field_bad;

endmodule

`default_nettype wire

/* File: core/sfs_fault_regs.sv */
// System fault and configuration parity status registers behind an AXI4-Lite slave
//
// Behaviour
// - The oscillator fault bit 7 of the system fault register follows the out-of-range detector, zero otherwise.
// - The digital reset bit 4 is set once an internal digital reset has taken place.
// - The thermal shutdown bit 1 reports that the previous shutdown was thermal, zero otherwise.
// - The warning bit 0 is high while die temperature 2 exceeds the level chosen by the two-bit threshold.
// - A die temperature warning triggers no protective action, it is only reported.
// - The temperature parity bit flags a parity error in temperature thresholds, mode or the four pin configs.
// - The voltage parity bit flags a parity error in voltage thresholds, mode or the four-bit cell count.
`timescale 1ns/1ps
`default_nettype none
`include "sfs_defines.svh"

module sfs_fault_regs
  import sfs_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_reset,
  // AXI4-Lite slave
  input wire logic [ADDR_WIDTH-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_WIDTH-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Fault sources and configuration
  input wire sfs_events_s i_events,
  input wire sfs_temp_cfg_s i_temp_cfg,
  input wire sfs_volt_cfg_s i_volt_cfg,
  output logic o_shutdown_request
);

  localparam logic [ADDR_WIDTH-1:0] ADDR_SYS = ADDR_WIDTH'(`SFS_IDX_SYS_FAULT * 4);
  localparam logic [ADDR_WIDTH-1:0] ADDR_PAR = ADDR_WIDTH'(`SFS_IDX_PARITY_FAULT * 4);
  localparam logic [ADDR_WIDTH-1:0] ADDR_CTL = ADDR_WIDTH'(`SFS_IDX_CONTROL * 4);

  // ----------------------------------------
  // Parity checking
  // ----------------------------------------
  logic temp_parity_err;
  logic volt_parity_err;

  sfs_parity_check #(
    .NUM_FIELDS(7),
    .FIELD_WIDTH(8)
  ) u_temp_parity (
    .i_fields({i_temp_cfg.ot_threshold, i_temp_cfg.ut_threshold, 6'h00, i_temp_cfg.temp_compare_mode,
               i_temp_cfg.pin_config_1, i_temp_cfg.pin_config_2, i_temp_cfg.pin_config_3,
               i_temp_cfg.pin_config_4}),
    .i_parity(i_temp_cfg.parity),
    .i_field_used(7'h7F),
    .o_error(temp_parity_err)
  );

  sfs_parity_check #(
    .NUM_FIELDS(4),
    .FIELD_WIDTH(8)
  ) u_volt_parity (
    .i_fields({i_volt_cfg.ov_threshold, i_volt_cfg.uv_threshold, 6'h00, i_volt_cfg.volt_compare_mode,
               4'h0, i_volt_cfg.active_cell_count}),
    .i_parity(i_volt_cfg.parity),
    .i_field_used(4'hF),
    .o_error(volt_parity_err)
  );

  // ----------------------------------------
  // Fault state
  // ----------------------------------------
  logic [7:0] sys_flags;
  logic [7:0] next_sys_flags;
  logic [7:0] parity_flags;
  logic [7:0] next_parity_flags;
  logic [7:0] control;
  logic [7:0] next_control;
  logic reset_seen;
  logic next_reset_seen;
  logic shutdown_request;
  logic next_shutdown_request;
  logic clear_sticky;
  logic [7:0] warn_level;

  always_comb begin
    case (control[`SFS_CTL_THR_MSB:`SFS_CTL_THR_LSB])
      2'h0: warn_level = `SFS_WARN_LVL0;
      2'h1: warn_level = `SFS_WARN_LVL1;
      2'h2: warn_level = `SFS_WARN_LVL2;
      2'h3: warn_level = `SFS_WARN_LVL3;
      default: warn_level = `SFS_WARN_LVL0;
    endcase
  end

  always_comb begin
    next_reset_seen = 1'b1;
    next_sys_flags = sys_flags;
    // Sticky bits first cleared, then set, so a same-cycle event wins
    if (clear_sticky) begin
      next_sys_flags[`SFS_SYS_DIGITAL_RESET_FLAG_BIT] = 1'b0;
      next_sys_flags[`SFS_SYS_EXT_FAULT_BIT] = 1'b0;
      next_sys_flags[`SFS_SYS_CTL_BIT] = 1'b0;
      next_sys_flags[`SFS_SYS_CTS_BIT] = 1'b0;
      next_sys_flags[`SFS_SYS_THERMAL_SHUTDOWN_FLAG_BIT] = 1'b0;
    end
    next_sys_flags[`SFS_SYS_OSC_BIT] = i_events.osc_out_of_range;
    next_sys_flags[`SFS_SYS_RSVD_BIT] = 1'b0;
    if (!reset_seen || i_events.digital_reset) begin
      next_sys_flags[`SFS_SYS_DIGITAL_RESET_FLAG_BIT] = 1'b1;
    end
    if (i_events.thermal_shutdown) begin
      next_sys_flags[`SFS_SYS_THERMAL_SHUTDOWN_FLAG_BIT] = 1'b1;
    end
    if (control[`SFS_CTL_FAULT_IN_EN_BIT] && i_events.ext_fault_pin) begin
      next_sys_flags[`SFS_SYS_EXT_FAULT_BIT] = 1'b1;
    end
    if (i_events.comm_timeout_long) begin
      next_sys_flags[`SFS_SYS_CTL_BIT] = 1'b1;
    end
    if (i_events.comm_timeout_short) begin
      next_sys_flags[`SFS_SYS_CTS_BIT] = 1'b1;
    end
    // Warning is reported only; nothing else reads it
    next_sys_flags[`SFS_SYS_DIE_TEMP_WARNING_FLAG_BIT] = (i_events.die_temp2 > warn_level);
    next_parity_flags = `SFS_RESET_VALUE;
    next_parity_flags[`SFS_PAR_TEMP_BIT] = temp_parity_err;
    next_parity_flags[`SFS_PAR_VOLT_BIT] = volt_parity_err;
    // Shutdown request holds until reset once issued
    next_shutdown_request = shutdown_request |
      (i_events.comm_timeout_long & control[`SFS_CTL_LONG_SHDN_EN_BIT]);
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_held;
  logic next_aw_held;
  logic w_held;
  logic next_w_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [ADDR_WIDTH-1:0] next_aw_addr;
  logic [7:0] w_byte;
  logic [7:0] next_w_byte;
  logic w_lane0;
  logic next_w_lane0;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic aw_take;
  logic w_take;
  logic do_write;

  assign aw_take = i_awvalid & o_awready;
  assign w_take = i_wvalid & o_wready;
  assign clear_sticky = do_write && aw_addr == ADDR_CTL && w_lane0 && w_byte[`SFS_CTL_CLEAR_BIT];

  always_comb begin
    next_aw_held = aw_held | aw_take;
    next_w_held = w_held | w_take;
    next_aw_addr = aw_take ? i_awaddr : aw_addr;
    next_w_byte = w_take ? i_wdata[7:0] : w_byte;
    next_w_lane0 = w_take ? i_wstrb[0] : w_lane0;
    next_bvalid = o_bvalid & ~i_bready;
    next_bresp = o_bresp;
    next_control = control;
    do_write = aw_held & w_held & ~o_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      if (aw_addr == ADDR_CTL) begin
        next_bresp = `SFS_RESP_OKAY;
        if (w_lane0) begin
          next_control = w_byte & `SFS_CTL_WRITE_MASK;
        end
      end else if (aw_addr == ADDR_SYS || aw_addr == ADDR_PAR) begin
        // Status registers ignore writes
        next_bresp = `SFS_RESP_OKAY;
      end else begin
        next_bresp = `SFS_RESP_SLVERR;
      end
    end
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;

    next_rvalid = o_rvalid & ~i_rready;
    next_rdata = o_rdata;
    next_rresp = o_rresp;
    if (i_arvalid && o_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `SFS_RESP_OKAY;
      if (i_araddr == ADDR_SYS) begin
        next_rdata = {24'h000000, sys_flags};
      end else if (i_araddr == ADDR_PAR) begin
        next_rdata = {24'h000000, parity_flags};
      end else if (i_araddr == ADDR_CTL) begin
        next_rdata = {24'h000000, control};
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = `SFS_RESP_SLVERR;
      end
    end
    next_arready = ~next_rvalid;
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sys_flags <= `SFS_RESET_VALUE;
      parity_flags <= `SFS_RESET_VALUE;
      control <= `SFS_RESET_VALUE;
      reset_seen <= 1'b0;
      shutdown_request <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= `SFS_RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h00000000;
      o_rresp <= `SFS_RESP_OKAY;
    end else begin
      sys_flags <= next_sys_flags;
      parity_flags <= next_parity_flags;
      control <= next_control;
      reset_seen <= next_reset_seen;
      shutdown_request <= next_shutdown_request;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      o_awready <= next_awready;
      o_wready <= next_wready;
      o_bvalid <= next_bvalid;
      o_bresp <= next_bresp;
      o_arready <= next_arready;
      o_rvalid <= next_rvalid;
      o_rdata <= next_rdata;
      o_rresp <= next_rresp;
    end
  end

  assign o_shutdown_request = shutdown_request;

endmodule

`default_nettype wire

/* File: verif/sfs_fault_regs_assertions.sv */
// Concurrent checks on the ports of the fault status register bank
`timescale 1ns/1ps
`default_nettype none
`include "sfs_defines.svh"
module sfs_fault_regs_checker
  import sfs_pkg::*;
#(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_bready,
  input wire logic [ADDR_WIDTH-1:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic o_bvalid,
  input wire logic i_rready,
  input wire sfs_events_s i_events,
  input wire sfs_temp_cfg_s i_temp_cfg,
  input wire sfs_volt_cfg_s i_volt_cfg,
  input wire logic o_shutdown_request
);
  localparam logic [ADDR_WIDTH-1:0] A_SYS = ADDR_WIDTH'({`SFS_IDX_SYS_FAULT, 2'b00});
  localparam logic [ADDR_WIDTH-1:0] A_PAR = ADDR_WIDTH'({`SFS_IDX_PARITY_FAULT, 2'b00});
  localparam logic [ADDR_WIDTH-1:0] A_CTL = ADDR_WIDTH'({`SFS_IDX_CONTROL, 2'b00});
  logic tk;
  logic t_err;
  logic v_err;
  logic osc;
  assign tk = i_arvalid && o_arready;
  assign osc = i_events.osc_out_of_range;
  // Even parity recomputed here, independent of the design's checker
  assign t_err = {^i_temp_cfg.ot_threshold, ^i_temp_cfg.ut_threshold, ^i_temp_cfg.temp_compare_mode,
    ^i_temp_cfg.pin_config_1, ^i_temp_cfg.pin_config_2, ^i_temp_cfg.pin_config_3,
    ^i_temp_cfg.pin_config_4} != i_temp_cfg.parity;
  assign v_err = {^i_volt_cfg.ov_threshold, ^i_volt_cfg.uv_threshold, ^i_volt_cfg.volt_compare_mode,
    ^i_volt_cfg.active_cell_count} != i_volt_cfg.parity;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  property p_rhold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  property p_bhold; o_bvalid && !i_bready |=> o_bvalid; endproperty
  property p_rlat; tk |=> o_rvalid; endproperty
  property p_upper; o_rvalid |-> o_rdata[31:8] == 24'h000000; endproperty
  property p_unmap;
    tk && i_araddr != A_SYS && i_araddr != A_PAR && i_araddr != A_CTL
      |=> o_rresp == `SFS_RESP_SLVERR && o_rdata == 32'h00000000;
  endproperty
  property p_osc;
    tk && i_araddr == A_SYS && $stable(osc) && $past(osc) == $past(osc, 2) |=> o_rdata[7] == $past(osc);
  endproperty
  property p_tpar;
    tk && i_araddr == A_PAR && $stable(t_err) && $past(t_err) == $past(t_err, 2) |=> o_rdata[1] == $past(t_err);
  endproperty
  property p_vpar;
    tk && i_araddr == A_PAR && $stable(v_err) && $past(v_err) == $past(v_err, 2) |=> o_rdata[0] == $past(v_err);
  endproperty
  property p_shdn;
    $rose(o_shutdown_request) |-> $past(i_events.comm_timeout_long) || $past(i_events.comm_timeout_long, 2)
      || $past(i_events.comm_timeout_long, 3);
  endproperty
  property p_sticky; o_shutdown_request |=> o_shutdown_request; endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  a_rlat: assert property (p_rlat) else $error("read answer late");
  a_upper: assert property (p_upper) else $error("upper read bits not zero");
  a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
  a_osc: assert property (p_osc) else $error("oscillator flag wrong");
  a_tpar: assert property (p_tpar) else $error("temperature parity flag wrong");
  a_vpar: assert property (p_vpar) else $error("voltage parity flag wrong");
  a_shdn: assert property (p_shdn) else $error("shutdown without long timeout");
  a_sticky: assert property (p_sticky) else $error("shutdown request dropped");
  c_sys: cover property (tk && i_araddr == A_SYS);
  c_shdn: cover property ($rose(o_shutdown_request));
  c_err: cover property (o_rvalid && o_rresp == `SFS_RESP_SLVERR);
endmodule
bind sfs_fault_regs sfs_fault_regs_checker #(.ADDR_WIDTH(ADDR_WIDTH)) i_chk (.i_clock, .i_reset, .i_bready,
  .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .o_bvalid, .i_rready, .i_events,
  .i_temp_cfg, .i_volt_cfg, .o_shutdown_request);
`default_nettype wire

/* File: verif/test_system_fault_status.sv */
// Self-checking bench for the fault status register bank
`timescale 1ns/1ps
`default_nettype none
`include "sfs_defines.svh"
module test_system_fault_status
  import sfs_pkg::*;
;
  localparam logic [15:0] A_SYS = 16'({`SFS_IDX_SYS_FAULT, 2'b00});
  localparam logic [15:0] A_PAR = 16'({`SFS_IDX_PARITY_FAULT, 2'b00});
  localparam logic [15:0] A_CTL = 16'({`SFS_IDX_CONTROL, 2'b00});
  localparam logic [1:0] OK = `SFS_RESP_OKAY;
  localparam logic [1:0] ER = `SFS_RESP_SLVERR;
  logic i_clock, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_shutdown_request;
  logic [15:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp;
  sfs_events_s i_events;
  sfs_temp_cfg_s i_temp_cfg;
  sfs_volt_cfg_s i_volt_cfg;
  logic [7:0] lv [4] = '{`SFS_WARN_LVL0, `SFS_WARN_LVL1, `SFS_WARN_LVL2, `SFS_WARN_LVL3};
  int failures = 0;
  int compares = 0;
  sfs_fault_regs #(.ADDR_WIDTH(16)) i_dut (.i_clock, .i_reset, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
    .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
    .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_events, .i_temp_cfg, .i_volt_cfg, .o_shutdown_request);
  initial begin
    {i_clock, i_reset} = 2'h1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    {i_awaddr, i_araddr, i_wdata, i_wstrb} = 68'h0;
    i_events = '0;
    i_temp_cfg = '0;
    i_volt_cfg = '0;
  end
  always #4 i_clock = ~i_clock;
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er, input logic [3:0] st = 4'hF);
    int n = 0;
    bit aw = 0;
    bit w = 0;
    i_awaddr <= a;
    i_wdata <= {24'h000000, d};
    i_wstrb <= st;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (o_awready && !aw) begin
        aw = 1;
        i_awvalid <= 1'b0;
      end
      if (o_wready && !w) begin
        w = 1;
        i_wvalid <= 1'b0;
      end
    end while (!(aw && w) && n < 50);
    i_bready <= 1'b1;
    do begin @(posedge i_clock); n++; end while (!o_bvalid && n < 100);
    i_bready <= 1'b0;
    if (n >= 100) failures++;
    check("bresp", 32'(er), 32'(o_bresp));
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic [1:0] er);
    int n = 0;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin @(posedge i_clock); n++; end while (!o_arready && n < 50);
    i_arvalid <= 1'b0;
    i_rready <= 1'b1;
    do begin @(posedge i_clock); n++; end while (!o_rvalid && n < 100);
    i_rready <= 1'b0;
    if (n >= 100) failures++;
    check("rdata", {24'h000000, e}, o_rdata);
    check("rresp", 32'(er), 32'(o_rresp));
  endtask
  // Event bit index into the packed struct; held three edges so the flag register samples it
  task automatic ev(input int b, input logic v);
    i_events[b] <= v;
    repeat (3) @(posedge i_clock);
  endtask
  task automatic finish_test;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clock);
    failures++;
    finish_test();
  end
  initial begin
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clock);
    rd(A_SYS, 8'h10, OK);
    rd(A_PAR, 8'h00, OK);
    wr(A_SYS, 8'hFF, OK);
    rd(A_SYS, 8'h10, OK);
    rd(16'h0004, 8'h00, ER);
    wr(16'h0004, 8'h01, ER);
    wr(A_CTL, 8'h80, OK);
    rd(A_SYS, 8'h00, OK);
    ev(11, 1'b1); ev(11, 1'b0);
    rd(A_SYS, 8'h10, OK);
    ev(13, 1'b1);
    rd(A_SYS, 8'h90, OK);
    ev(13, 1'b0);
    rd(A_SYS, 8'h10, OK);
    ev(8, 1'b1); ev(8, 1'b0);
    rd(A_SYS, 8'h12, OK);
    ev(9, 1'b1); ev(9, 1'b0); ev(10, 1'b1); ev(10, 1'b0);
    rd(A_SYS, 8'h1E, OK);
    ev(12, 1'b1);
    rd(A_SYS, 8'h1E, OK);
    wr(A_CTL, 8'h04, OK);
    // Lane 0 disabled: neither the control bits nor the clear may land
    wr(A_CTL, 8'h80, OK, 4'h0);
    rd(A_CTL, 8'h04, OK);
    rd(A_SYS, 8'h3E, OK);
    ev(12, 1'b0);
    wr(A_CTL, 8'h80, OK);
    rd(A_SYS, 8'h00, OK);
    for (int c = 0; c < 4; c++) begin
      wr(A_CTL, 8'(c), OK);
      i_events.die_temp2 <= lv[c];
      repeat (3) @(posedge i_clock);
      rd(A_SYS, 8'h00, OK);
      i_events.die_temp2 <= lv[c] + 8'h01;
      repeat (3) @(posedge i_clock);
      rd(A_SYS, 8'h01, OK);
    end
    check("shutdown", 32'h00000000, 32'(o_shutdown_request));
    i_events.die_temp2 <= 8'h00;
    wr(A_CTL, 8'h08, OK);
    ev(10, 1'b1); ev(10, 1'b0);
    rd(A_SYS, 8'h08, OK);
    check("shutdown", 32'h00000001, 32'(o_shutdown_request));
    for (int i = 0; i < 7; i++) begin
      i_temp_cfg.parity <= 7'h01 << i;
      repeat (3) @(posedge i_clock);
      rd(A_PAR, 8'h02, OK);
    end
    i_temp_cfg.parity <= 7'h40;
    i_temp_cfg.ot_threshold <= 8'h01;
    for (int i = 0; i < 4; i++) begin
      i_volt_cfg.parity <= 4'h1 << i;
      repeat (3) @(posedge i_clock);
      rd(A_PAR, 8'h01, OK);
    end
    i_volt_cfg.parity <= 4'h0;
    repeat (3) @(posedge i_clock);
    rd(A_PAR, 8'h00, OK);
    // Mid-run reset: shutdown request drops, digital reset flag comes back
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clock);
    check("shutdown", 32'h00000000, 32'(o_shutdown_request));
    rd(A_SYS, 8'h10, OK);
    finish_test();
  end
endmodule
`default_nettype wire
